// [pkg/cfg_defines.svh]
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
// Function
// RULE_01 - Chip OE low tri-states user I/O.
// RULE_02 - Chip OE option off: plain user pin.
// RULE_03 - Init-done pin low throughout configuration.
// RULE_04 - Init-done pin released in user mode.
// RULE_05 - Init-done option off: pin is user I/O.
// RULE_06 - Compression on: decompress serial bitstream.
// RULE_07 - Compression off: load bits unchanged.
// RULE_08 - Two-bit scheme select picks the scheme.
// RULE_09 - Host keeps scheme select steady throughout.
// RULE_10 - Request low: reset, discard, tri-state all. Config-done stays driven low; init-done stays low or follows user_aux_oe.
// RULE_11 - Request rising starts reconfiguration.
// RULE_12 - Request synchronised, rising edge detected.
// RULE_13 - Config-done low until data complete.
// RULE_14 - Error drives status line low.
// RULE_15 - External status low errors, except user mode.
// RULE_16 - Passive serial bits taken on clock rise.
`define CLK_PERIOD_NS 4
`define AS_HALF_NS 20
`define AS_HALF_CYC (`AS_HALF_NS / `CLK_PERIOD_NS)
`define ADDR_CTRL 4'h0
`define ADDR_STATE 4'h4
`define ADDR_IRQ_ST 4'h8
`define ADDR_IRQ_MASK 4'hc
`define CTRL_OE_BIT 0
`define CTRL_INIT_BIT 1
`define CTRL_COMP_BIT 2
`define CTRL_RESET 3'h0
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define IRQ_RST_BIT 2
`define SCHEME_PS 2'h0
`define SCHEME_AS 2'h1
`define TOK_LAST 2'h3
`endif

// [pkg/cfg_pkg.sv]
package cfg_pkg;
    typedef enum logic [4:0] {
        ST_RESET  = 5'h01,
        ST_CONFIG = 5'h02,
        ST_INIT   = 5'h04,
        ST_USER   = 5'h08,
        ST_ERROR  = 5'h10
    } state_t;
    typedef struct packed {
        state_t      state;
        logic [1:0]  scheme;
        logic [2:0]  ctrl;
        logic [2:0]  req_s, clk_s, dat_s, stat_s, choe_s, hi_s, lo_s;
        logic        req_lvl, req_prev, clk_lvl, dat_lvl;
        logic        stat_lvl, choe_lvl, hi_lvl, lo_lvl;
        logic [15:0] bitcnt;
        logic [3:0]  tok;
        logic [1:0]  tokn;
        logic [2:0]  run;
        logic        run_act, run_val, par, exp_chk;
        logic [7:0]  init_cnt, div_cnt;
        logic        as_clk;
        logic [2:0]  irq_st, irq_mask;
        logic        irq;
        logic [31:0] rdata;
        logic        cfg_we, cfg_bit;
        logic        status_oe, done_oe, init_oe, init_out;
        logic        user_io_oe, chip_oe_user, cclk_oe, cfg_valid;
    } st_t;
endpackage

// [hdl/fpga_config_control.sv]
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "cfg_defines.svh"
module fpga_config_control #(
    parameter int CONFIG_BITS = 64,
    parameter int INIT_CYCLES = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        config_request_n,
    input  wire logic        scheme_select_hi,
    input  wire logic        scheme_select_lo,
    input  wire logic        config_clock_in,
    output logic             config_clock_out,
    output logic             config_clock_oe,
    input  wire logic        config_data_in,
    input  wire logic        config_status_od_n_in,
    output logic             config_status_od_n_out,
    output logic             config_status_od_n_oe,
    output logic             config_done_od_out,
    output logic             config_done_od_oe,
    output logic             init_done_out,
    output logic             init_done_oe,
    input  wire logic        user_aux_out,
    input  wire logic        user_aux_oe,
    input  wire logic        chip_output_enable_in,
    output logic             chip_oe_user_in,
    output logic             user_io_oe,
    output logic             cfg_we,
    output logic             cfg_bit,
    output logic             cfg_valid
);
    cfg_pkg::st_t r, n;
    logic bit_edge, raw, emit, emit_b, clr_ev, err_ev;
    logic [15:0] cnt_next;
    logic [3:0]  tok_next;
    logic [2:0]  ev, clr;

    // Level counts once the second and third stages agree.
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    always_comb begin
        n = r;
        ev = 3'h0;
        clr = 3'h0;
        emit = 1'b0;
        emit_b = 1'b0;
        err_ev = 1'b0;
        clr_ev = 1'b0;
        cnt_next = r.bitcnt + 16'h1;
        tok_next = {r.tok[2:0], 1'b0};
        n.rdata = 32'h0;
        n.cfg_we = 1'b0;
        n.req_s = {r.req_s[1:0], config_request_n};
        n.clk_s = {r.clk_s[1:0], config_clock_in};
        n.dat_s = {r.dat_s[1:0], config_data_in};
        n.stat_s = {r.stat_s[1:0], config_status_od_n_in};
        n.choe_s = {r.choe_s[1:0], chip_output_enable_in};
        n.hi_s = {r.hi_s[1:0], scheme_select_hi};
        n.lo_s = {r.lo_s[1:0], scheme_select_lo};
        n.req_lvl = filt(r.req_s, r.req_lvl); // RULE_12
        n.clk_lvl = filt(r.clk_s, r.clk_lvl);
        n.dat_lvl = filt(r.dat_s, r.dat_lvl);
        n.stat_lvl = filt(r.stat_s, r.stat_lvl);
        n.choe_lvl = filt(r.choe_s, r.choe_lvl);
        n.hi_lvl = filt(r.hi_s, r.hi_lvl);
        n.lo_lvl = filt(r.lo_s, r.lo_lvl);
        n.req_prev = r.req_lvl;
        raw = n.dat_lvl;
        // Active serial clock comes from a divider of the core clock.
        n.as_clk = 1'b0;
        n.div_cnt = 8'h0;
        if (r.state == cfg_pkg::ST_CONFIG && r.scheme == `SCHEME_AS) begin
            n.as_clk = r.as_clk;
            n.div_cnt = r.div_cnt + 8'h1;
            if (r.div_cnt == 8'(`AS_HALF_CYC - 1)) begin
                n.div_cnt = 8'h0;
                n.as_clk = ~r.as_clk;
            end
        end
        if (r.scheme == `SCHEME_AS)
            bit_edge = n.as_clk & ~r.as_clk;
        else
            bit_edge = n.clk_lvl & ~r.clk_lvl; // RULE_16
        if (!r.req_lvl) begin
            n.state = cfg_pkg::ST_RESET; // RULE_10
            clr_ev = (r.state != cfg_pkg::ST_RESET);
        end else begin
            case (r.state)
                cfg_pkg::ST_RESET: begin
                    if (r.req_lvl && !r.req_prev) begin // RULE_11 RULE_12
                        n.scheme = {r.hi_lvl, r.lo_lvl}; // RULE_08
                        n.bitcnt = 16'h0;
                        n.tokn = 2'h0;
                        n.run_act = 1'b0;
                        n.par = 1'b0;
                        n.exp_chk = 1'b0;
                        n.init_cnt = 8'h0;
                        if (n.scheme == `SCHEME_PS || n.scheme == `SCHEME_AS)
                            n.state = cfg_pkg::ST_CONFIG;
                        else
                            err_ev = 1'b1;
                    end
                end
                cfg_pkg::ST_CONFIG: begin
                    if (!r.stat_lvl) begin
                        err_ev = 1'b1; // RULE_15
                    end else if (bit_edge && r.exp_chk) begin
                        if (raw != r.par)
                            err_ev = 1'b1; // RULE_14
                        else
                            n.state = cfg_pkg::ST_INIT; // RULE_13
                    end else if (bit_edge && !r.ctrl[`CTRL_COMP_BIT]) begin
                        emit = 1'b1; // RULE_07
                        emit_b = raw;
                    end else if (bit_edge) begin
                        tok_next = {r.tok[2:0], raw}; // RULE_06
                        n.tok = tok_next;
                        n.tokn = r.tokn + 2'h1;
                        if (r.tokn == `TOK_LAST) begin
                            n.run_act = 1'b1;
                            n.run_val = tok_next[3];
                            n.run = tok_next[2:0];
                        end
                    end
                    if (r.run_act && !r.exp_chk) begin
                        emit = 1'b1; // RULE_06
                        emit_b = r.run_val;
                        n.run = r.run - 3'h1;
                        n.run_act = (r.run != 3'h0);
                    end
                    if (emit) begin
                        n.cfg_we = 1'b1;
                        n.cfg_bit = emit_b;
                        n.par = r.par ^ emit_b;
                        n.bitcnt = cnt_next;
                        if (cnt_next == 16'(CONFIG_BITS)) begin
                            n.exp_chk = 1'b1;
                            n.run_act = 1'b0;
                        end
                    end
                end
                cfg_pkg::ST_INIT: begin
                    if (!r.stat_lvl) begin
                        err_ev = 1'b1; // RULE_15
                    end else if (r.init_cnt == 8'(INIT_CYCLES - 1)) begin
                        n.state = cfg_pkg::ST_USER;
                        ev[`IRQ_DONE_BIT] = 1'b1;
                    end else begin
                        n.init_cnt = r.init_cnt + 8'h1;
                    end
                end
                cfg_pkg::ST_USER: n.state = cfg_pkg::ST_USER; // RULE_15
                cfg_pkg::ST_ERROR: n.state = cfg_pkg::ST_ERROR;
                default: n.state = cfg_pkg::ST_RESET;
            endcase
        end
        if (err_ev)
            n.state = cfg_pkg::ST_ERROR;
        ev[`IRQ_ERR_BIT] = err_ev;
        ev[`IRQ_RST_BIT] = clr_ev;
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL: n.ctrl = reg_wdata[2:0];
                `ADDR_IRQ_ST: clr = reg_wdata[2:0];
                `ADDR_IRQ_MASK: n.irq_mask = reg_wdata[2:0];
                default: n.ctrl = r.ctrl;
            endcase
        end
        n.irq_st = (r.irq_st & ~clr) | ev;
        n.irq = |(n.irq_st & n.irq_mask);
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: n.rdata = {29'h0, r.ctrl};
                `ADDR_STATE: n.rdata = {r.bitcnt, 9'h0, r.scheme, r.state};
                `ADDR_IRQ_ST: n.rdata = {29'h0, r.irq_st};
                `ADDR_IRQ_MASK: n.rdata = {29'h0, r.irq_mask};
                default: n.rdata = 32'h0;
            endcase
        end
        n.status_oe = (n.state == cfg_pkg::ST_ERROR); // RULE_14
        n.done_oe = (n.state != cfg_pkg::ST_INIT) &&
                    (n.state != cfg_pkg::ST_USER); // RULE_13
        if (n.ctrl[`CTRL_INIT_BIT]) begin
            n.init_oe = (n.state != cfg_pkg::ST_USER); // RULE_03 RULE_04
            n.init_out = 1'b0;
        end else begin
            n.init_oe = user_aux_oe; // RULE_05
            n.init_out = user_aux_out;
        end
        n.user_io_oe = (n.state == cfg_pkg::ST_USER) &&
                       (!n.ctrl[`CTRL_OE_BIT] || n.choe_lvl); // RULE_01
        n.chip_oe_user = n.ctrl[`CTRL_OE_BIT] ? 1'b0 : n.choe_lvl; // RULE_02
        n.cclk_oe = (n.state == cfg_pkg::ST_CONFIG) &&
                    (n.scheme == `SCHEME_AS);
        n.cfg_valid = (n.state == cfg_pkg::ST_USER); // RULE_10
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.state <= cfg_pkg::ST_RESET;
            r.ctrl <= `CTRL_RESET;
            r.done_oe <= 1'b1;
            r.stat_lvl <= 1'b1;
            r.stat_s <= 3'h7;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq = r.irq;
    assign config_clock_out = r.as_clk;
    assign config_clock_oe = r.cclk_oe;
    assign config_status_od_n_out = 1'b0;
    assign config_status_od_n_oe = r.status_oe;
    assign config_done_od_out = 1'b0;
    assign config_done_od_oe = r.done_oe;
    assign init_done_out = r.init_out;
    assign init_done_oe = r.init_oe;
    assign chip_oe_user_in = r.chip_oe_user;
    assign user_io_oe = r.user_io_oe;
    assign cfg_we = r.cfg_we;
    assign cfg_bit = r.cfg_bit;
    assign cfg_valid = r.cfg_valid;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CHIP_OE_LOW: assert property ( // RULE_01
        r.ctrl[`CTRL_OE_BIT] && !r.choe_s[1] && !r.choe_s[2] && !r.choe_lvl
        |=> !user_io_oe) else $error("user I/O driven with chip OE low");
    AST_CHIP_OE_OFF: assert property ( // RULE_02
        !r.ctrl[`CTRL_OE_BIT] && r.state == cfg_pkg::ST_USER
        |-> user_io_oe && !chip_oe_user_in == !r.choe_lvl)
        else $error("chip OE pin not passed as user pin");
    AST_INIT_LOW: assert property ( // RULE_03
        r.ctrl[`CTRL_INIT_BIT] && r.state == cfg_pkg::ST_CONFIG
        |-> init_done_oe && !init_done_out)
        else $error("init-done not low in configuration");
    AST_INIT_REL: assert property ( // RULE_04
        r.ctrl[`CTRL_INIT_BIT] && $rose(r.state == cfg_pkg::ST_USER)
        |-> !init_done_oe) else $error("init-done not released");
    AST_INIT_USER: assert property ( // RULE_05
        !r.ctrl[`CTRL_INIT_BIT] && $past(!r.ctrl[`CTRL_INIT_BIT])
        |-> init_done_oe == $past(user_aux_oe))
        else $error("init-done pin not user I/O");
    AST_DONE_LOW: assert property ( // RULE_13
        r.state == cfg_pkg::ST_CONFIG |-> config_done_od_oe ##1
        (r.state != cfg_pkg::ST_INIT || !config_done_od_oe))
        else $error("config-done wrong");
    AST_REQ_LOW: assert property ( // RULE_10
        !r.req_lvl |=> r.state == cfg_pkg::ST_RESET && !user_io_oe
        && !cfg_valid) else $error("request low did not reset");
    AST_REQ_RISE: assert property ( // RULE_12
        $rose(r.req_lvl) && r.state == cfg_pkg::ST_RESET
        |=> r.state inside {cfg_pkg::ST_CONFIG, cfg_pkg::ST_ERROR})
        else $error("rising request did not start");
    AST_ERR_DRIVE: assert property ( // RULE_14
        r.state == cfg_pkg::ST_ERROR |-> config_status_od_n_oe)
        else $error("error without status low");
    AST_USER_HOLD: assert property ( // RULE_15
        r.state == cfg_pkg::ST_USER && r.req_lvl
        |=> r.state == cfg_pkg::ST_USER) else $error("user mode left");

    AST_PS_BIT: assert property ( // RULE_16
        $rose(r.clk_lvl) && $past(r.state == cfg_pkg::ST_CONFIG
        && r.req_lvl && r.stat_lvl && r.scheme == `SCHEME_PS && !r.run_act
        && !r.ctrl[`CTRL_COMP_BIT] && !r.exp_chk)
        |-> cfg_we && cfg_bit == r.dat_lvl)
        else $error("passive serial bit not taken on clock rise");
    AST_PLAIN_BIT: assert property ( // RULE_07
        r.state == cfg_pkg::ST_CONFIG && r.req_lvl && r.stat_lvl
        && bit_edge && !r.ctrl[`CTRL_COMP_BIT] && !r.exp_chk && !r.run_act
        |=> cfg_we && cfg_bit == r.dat_lvl)
        else $error("plain bit not loaded unchanged");
    AST_RUN_COPY: assert property ( // RULE_06
        r.state == cfg_pkg::ST_CONFIG && r.req_lvl && r.run_act
        && !r.exp_chk |=> cfg_we && cfg_bit == $past(r.run_val))
        else $error("run copy not emitted");
    AST_CHECK_PASS: assert property ( // RULE_13
        r.state == cfg_pkg::ST_CONFIG && r.req_lvl && r.stat_lvl
        && bit_edge && r.exp_chk && raw == r.par
        |=> r.state == cfg_pkg::ST_INIT && !config_done_od_oe)
        else $error("good check bit did not start init");
    AST_CHECK_FAIL: assert property ( // RULE_14
        r.state == cfg_pkg::ST_CONFIG && r.req_lvl && bit_edge
        && r.exp_chk && raw != r.par
        |=> r.state == cfg_pkg::ST_ERROR && config_status_od_n_oe)
        else $error("bad check bit did not raise error");
    AST_SCHEME_LATCH: assert property ( // RULE_08
        $rose(r.req_lvl) && r.state == cfg_pkg::ST_RESET
        |=> r.scheme == $past({r.hi_lvl, r.lo_lvl}))
        else $error("scheme not taken from select pins");
    AST_AS_CLOCK: assert property ( // RULE_08
        r.state == cfg_pkg::ST_CONFIG
        |-> config_clock_oe == (r.scheme == `SCHEME_AS))
        else $error("configuration clock drive wrong for scheme");
    AST_REQ_FILTER: assert property ( // RULE_12
        $changed(r.req_lvl) |-> $past(r.req_s[1]) == r.req_lvl
        && $past(r.req_s[2]) == r.req_lvl)
        else $error("request level changed without agreement");
    AST_CLEAR_FLAG: assert property ( // RULE_10
        !r.req_lvl && r.state != cfg_pkg::ST_RESET
        |=> r.irq_st[`IRQ_RST_BIT]) else $error("clear event not flagged");

    COV_USER: cover property ($rose(r.state == cfg_pkg::ST_USER));
    COV_ERROR: cover property ($rose(r.state == cfg_pkg::ST_ERROR));
    COV_COMP: cover property (r.run_act ##1 cfg_we);
    COV_AS: cover property (config_clock_oe && $rose(config_clock_out));
    COV_PS_BIT: cover property (cfg_we && r.scheme == `SCHEME_PS);
endmodule // fpga_config_control

// [verification/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
    input  logic as_clock,
    output logic config_clock_in,
    output logic config_data_in
);
    initial begin
        config_clock_in = 1'b0;
        config_data_in  = 1'b1;
    end
    // Data is set while the clock is low and taken on the rise.
    task automatic send_bit(input logic b);
        config_data_in <= b;
        #40;
        config_clock_in <= 1'b1;
        #40;
        config_clock_in <= 1'b0;
    endtask
    // A serial memory moves to its next bit on each falling edge.
    task automatic as_frame(input logic [8:0] raw);
        config_data_in <= raw[8];
        for (int i = 7; i >= 0; i--) begin
            @(negedge as_clock);
            config_data_in <= raw[i];
        end
        @(negedge as_clock);
    endtask
    // The clock stands low between frames and stale data is inverted.
    task automatic idle();
        config_data_in <= ~config_data_in;
    endtask
endmodule // serial_host_model

// [verification/fpga_config_control_tb_top.sv]
`timescale 1ns/1ps
module fpga_config_control_tb_top;
    logic        clk, rst_n, reg_wr, reg_rd, irq, req_n, sel_hi, sel_lo;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        config_clock, ddat, stat_oe, ext_pull, stat_wire, done_oe;
    logic        init_oe, aux_out, aux_oe, chip_oe, oe_user, io_oe;
    logic        cfg_we, cfg_bit, cfg_valid, rd_d;
    logic        as_clk, as_oe, stat_out, done_out, init_out;
    logic [7:0]  rnd;
    int          mismatches, tests_run, cycles;
    logic [31:0] rd_exp[$], rd_mask[$];
    logic        bit_exp[$];
    assign stat_wire = ((stat_oe && !stat_out) || ext_pull) ? 1'b0 : 1'b1;
    serial_host_model host (.as_clock(as_clk), .config_clock_in(config_clock),
        .config_data_in(ddat));
    fpga_config_control #(.CONFIG_BITS(8), .INIT_CYCLES(4)) DUT (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .config_request_n(req_n),
        .scheme_select_hi(sel_hi), .scheme_select_lo(sel_lo),
        .config_clock_in(config_clock), .config_clock_out(as_clk),
        .config_clock_oe(as_oe),
        .config_data_in(ddat), .config_status_od_n_in(stat_wire),
        .config_status_od_n_out(stat_out), .config_status_od_n_oe(stat_oe),
        .config_done_od_out(done_out), .config_done_od_oe(done_oe),
        .init_done_out(init_out), .init_done_oe(init_oe),
        .user_aux_out(aux_out), .user_aux_oe(aux_oe),
        .chip_output_enable_in(chip_oe), .chip_oe_user_in(oe_user),
        .user_io_oe(io_oe), .cfg_we(cfg_we), .cfg_bit(cfg_bit),
        .cfg_valid(cfg_valid));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        @(posedge clk);
        rd_exp.push_back(e);
        rd_mask.push_back(m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic start(input logic [1:0] sch);
        @(posedge clk);
        req_n            <= 1'b0;
        {sel_hi, sel_lo} <= sch;
        repeat (8) @(posedge clk);
        req_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic frame(input logic [8:0] raw);
        for (int i = 8; i >= 0; i--) host.send_bit(raw[i]);
        host.idle();
    endtask
    task automatic wait_user();
        int n;
        n = 0;
        while (cfg_valid !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(32'(cfg_valid), 32'h1);
    endtask
    // Results are compared against the oldest queued expectation.
    always @(posedge clk) begin
        rd_d   <= reg_rd;
        cycles <= cycles + 1;
        if (rd_d) chk(reg_rdata & rd_mask.pop_front(), rd_exp.pop_front());
        if (cfg_we) chk(32'(cfg_bit), 32'(bit_exp.pop_front()));
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, req_n} = '0;
        {sel_hi, sel_lo, ext_pull, aux_out, aux_oe} = '0;
        chip_oe    = 1'b1;
        mismatches = 0;
        tests_run  = 0;
        void'($urandom(49));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(4'h0, 32'h0, 32'h7);
        rd(4'h4, 32'h1, 32'h1f);
        rd(4'h2, 32'h0, 32'hffffffff);
        @(posedge clk);
        req_n <= 1'b1;
        @(posedge clk);
        req_n <= 1'b0;
        repeat (10) @(posedge clk);
        rd(4'h4, 32'h1, 32'h1f);
        wr(4'hc, 32'h7);
        $display("test reset done");
        wr(4'h0, 32'h3);
        start(2'h0);
        chk(32'(init_oe), 32'h1);
        chk(32'(init_out), 32'h0);
        chk(32'(as_oe), 32'h0);
        chk(32'(done_oe), 32'h1);
        chk(32'(io_oe), 32'h0);
        rnd = 8'($urandom());
        for (int i = 7; i >= 0; i--) bit_exp.push_back(rnd[i]);
        frame({rnd, ^rnd});
        wait_user();
        chk(32'(done_oe), 32'h0);
        chk(32'(done_out), 32'h0);
        chk(32'(init_oe), 32'h0);
        chk(32'(io_oe), 32'h1);
        chip_oe <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(io_oe), 32'h0);
        chip_oe  <= 1'b1;
        ext_pull <= 1'b1;
        repeat (8) @(posedge clk);
        rd(4'h4, 32'h8, 32'h1f);
        ext_pull <= 1'b0;
        rd(4'h8, 32'h1, 32'h1);
        chk(32'(irq), 32'h1);
        wr(4'hc, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        wr(4'hc, 32'h7);
        wr(4'h8, 32'h7);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("test plain load done");
        req_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(io_oe), 32'h0);
        chk(32'(done_oe), 32'h1);
        rd(4'h4, 32'h1, 32'h1f);
        rd(4'h8, 32'h4, 32'h4);
        $display("test clear done");
        wr(4'h0, 32'h4);
        chip_oe <= 1'b0;
        aux_oe  <= 1'b1;
        aux_out <= 1'b1;
        start(2'h0);
        chk(32'(init_oe), 32'h1);
        chk(32'(init_out), 32'h1);
        chk(32'(oe_user), 32'h0);
        for (int i = 0; i < 8; i++) bit_exp.push_back(i < 3);
        frame(9'b1010_0100_1);
        wait_user();
        chk(32'(io_oe), 32'h1);
        chip_oe <= 1'b1;
        aux_oe  <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(oe_user), 32'h1);
        chk(32'(init_oe), 32'h0);
        $display("test compressed done");
        wr(4'h0, 32'h0);
        start(2'h0);
        rnd = 8'($urandom());
        for (int i = 7; i >= 0; i--) bit_exp.push_back(rnd[i]);
        frame({rnd, ~^rnd});
        repeat (20) @(posedge clk);
        chk(32'(stat_oe), 32'h1);
        chk(32'(stat_out), 32'h0);
        chk(32'(done_oe), 32'h1);
        rd(4'h4, 32'h10, 32'h1f);
        rd(4'h8, 32'h2, 32'h2);
        start(2'h2 | 2'($urandom_range(1)));
        rd(4'h4, 32'h10, 32'h1f);
        start(2'h0);
        chk(32'(stat_oe), 32'h0);
        bit_exp.push_back(1'b1);
        host.send_bit(1'b1);
        host.idle();
        @(posedge clk);
        ext_pull <= 1'b1;
        repeat (8) @(posedge clk);
        rd(4'h4, 32'h10, 32'h1f);
        ext_pull <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(bit_exp.size()), 32'h0);
        $display("test errors done");
        wr(4'h0, 32'h6);
        for (int i = 0; i < 8; i++) bit_exp.push_back(i >= 4);
        fork
            host.as_frame(9'b0011_1011_0);
            begin
                start(2'h1);
                chk(32'(as_oe), 32'h1);
            end
        join
        host.idle();
        wait_user();
        chk(32'(as_oe), 32'h0);
        chk(32'(bit_exp.size()), 32'h0);
        $display("test active serial done");
        end_sim();
    end
endmodule // fpga_config_control_tb_top
